// >>> dtetc_regs.vh
// register offsets, field positions, reset values and codes for the block
`ifndef DTETC_REGS_VH
`define DTETC_REGS_VH
`define DTETC_ADDR_CMD 16'h1C09
`define DTETC_ADDR_WDATA 16'h1C0A
`define DTETC_ADDR_RDATA 16'h1C0B
`define DTETC_ADDR_EGRESS 16'h1C0C
`define DTETC_CMD_RW_BIT 4
`define DTETC_CMD_IDX_HI 3
`define DTETC_CMD_IDX_LO 0
`define DTETC_PROB_W 10
`define DTETC_PROB_RST 10'h000
`define DTETC_EGR_RST 23'h000000
`define DTETC_CMD_RST 5'h00
`define DTETC_RDATA_RST 32'h00000000
`define DTETC_EGR_MASK 32'h007F7F7F
`define DTETC_PORT_STRIDE 8
`define DTETC_TYPE_LO 0
`define DTETC_CHG_TAG_BIT 2
`define DTETC_CHG_PRI_BIT 3
`define DTETC_CHG_VID_BIT 4
`define DTETC_INSERT_BIT 5
`define DTETC_SRC_SEL_BIT 6
`define DTETC_TYPE_HYBRID 2'h2
`endif

// >>> dtetc_table_mem.v
// sixteen-entry drop probability memory with registered read data
`timescale 1ns/1ps
module dtetc_table_mem #(
  parameter DW = 10,
  parameter AW = 4
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents stay undefined until written
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // dtetc_table_mem

// >>> dtetc_tag_edit.v
// per-port hybrid egress tag edit decision, combinational
`timescale 1ns/1ps
`include "dtetc_regs.vh"
module dtetc_tag_edit (
  input wire [6:0] cfg_i,
  input wire pkt_tagged_i,
  input wire [11:0] pkt_vid_i,
  input wire untag_default_i,
  input wire untag_incoming_i,
  output reg insert_o,
  output reg strip_o,
  output reg vid_rewrite_o,
  output reg pri_rewrite_o,
  output reg use_egress_src_o
);
  wire hybrid;
  wire prio_tagged;
  wire reg_tagged;
  assign hybrid = (cfg_i[1:0] == `DTETC_TYPE_HYBRID);
  assign prio_tagged = pkt_tagged_i && (pkt_vid_i == 12'h000);
  assign reg_tagged = pkt_tagged_i && (pkt_vid_i != 12'h000);

  // all edits gated by hybrid type; untag bit wins over rewrite
  always @* begin
    insert_o = 1'b0;
    strip_o = 1'b0;
    vid_rewrite_o = 1'b0;
    pri_rewrite_o = 1'b0;
    use_egress_src_o = hybrid && cfg_i[`DTETC_SRC_SEL_BIT];
    if (hybrid) begin
      if (!pkt_tagged_i) begin
        insert_o = cfg_i[`DTETC_INSERT_BIT] && !untag_default_i;
      end else if (untag_incoming_i) begin
        strip_o = 1'b1;
      end else begin
        vid_rewrite_o = prio_tagged || (reg_tagged &&
          cfg_i[`DTETC_CHG_VID_BIT] && cfg_i[`DTETC_CHG_TAG_BIT]);
        pri_rewrite_o = cfg_i[`DTETC_CHG_PRI_BIT] && (prio_tagged ||
          (reg_tagged && cfg_i[`DTETC_CHG_TAG_BIT]));
      end
    end
  end
endmodule // dtetc_tag_edit

// >>> dtetc_top.v
// discard table access and egress tagging configuration block
`timescale 1ns/1ps
`include "dtetc_regs.vh"
module dtetc_top #(
  parameter NPORT = 3
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  input wire [3:0] lookup_idx_i,
  output reg [9:0] lookup_prob_o,
  input wire [NPORT-1:0] pkt_tagged_i,
  input wire [12*NPORT-1:0] pkt_vid_i,
  input wire [NPORT-1:0] untag_default_i,
  input wire [NPORT-1:0] untag_incoming_i,
  output reg [NPORT-1:0] insert_o,
  output reg [NPORT-1:0] strip_o,
  output reg [NPORT-1:0] vid_rewrite_o,
  output reg [NPORT-1:0] pri_rewrite_o,
  output reg [NPORT-1:0] use_egress_src_o
);
  reg [`DTETC_PROB_W-1:0] wdata_q;
  reg [`DTETC_PROB_W-1:0] rdata_q;
  reg [22:0] egr_q;
  reg [4:0] cmd_q;
  reg [1:0] rd_pend_q;
  reg [`DTETC_PROB_W-1:0] shadow [0:15];
  wire [`DTETC_PROB_W-1:0] mem_rdata;
  wire cmd_wr;
  wire [31:0] egr_wmask;
  wire tbl_we;
  wire tbl_rd;
  wire [3:0] cmd_idx;
  wire [NPORT-1:0] ins_w;
  wire [NPORT-1:0] strip_w;
  wire [NPORT-1:0] vid_w;
  wire [NPORT-1:0] pri_w;
  wire [NPORT-1:0] src_w;

  assign cmd_wr = reg_wr_i && (reg_addr_i == `DTETC_ADDR_CMD);
  // reserved bits of the egress register are dropped at write time
  assign egr_wmask = reg_wdata_i & `DTETC_EGR_MASK;
  assign cmd_idx = reg_wdata_i[`DTETC_CMD_IDX_HI:`DTETC_CMD_IDX_LO];
  // command write triggers the access; bit 4 picks direction
  assign tbl_we = cmd_wr && !reg_wdata_i[`DTETC_CMD_RW_BIT];
  assign tbl_rd = cmd_wr && reg_wdata_i[`DTETC_CMD_RW_BIT];

  // host-facing memory: read port follows the command index
  dtetc_table_mem #(
    .DW(`DTETC_PROB_W),
    .AW(4)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(tbl_we),
    .waddr_i(cmd_idx),
    .wdata_i(wdata_q),
    .raddr_i(cmd_q[3:0]),
    .rdata_o(mem_rdata)
  );

  // second copy for the discard engine lookup; trades area for no port clash
  always @(posedge clk_i) begin
    if (tbl_we) begin
      shadow[cmd_idx] <= wdata_q;
    end
  end

  // registers with reset; read result taken two cycles after the command:
  // one edge to load cmd_q, one for the memory's registered read port
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdata_q <= `DTETC_PROB_RST;
      rdata_q <= `DTETC_PROB_RST;
      egr_q <= `DTETC_EGR_RST;
      cmd_q <= `DTETC_CMD_RST;
      rd_pend_q <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `DTETC_ADDR_WDATA) begin
        wdata_q <= reg_wdata_i[`DTETC_PROB_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == `DTETC_ADDR_EGRESS) begin
        egr_q <= egr_wmask[22:0];
      end
      if (cmd_wr) begin
        cmd_q <= reg_wdata_i[4:0];
      end
      rd_pend_q <= {rd_pend_q[0], tbl_rd};
      if (rd_pend_q[1]) begin
        rdata_q <= mem_rdata;
      end
    end
  end

  // register read mux; unmapped and reserved bits read zero
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `DTETC_RDATA_RST;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DTETC_ADDR_CMD: reg_rdata_o <= {27'h0000000, cmd_q};
        `DTETC_ADDR_WDATA: reg_rdata_o <= {22'h000000, wdata_q};
        `DTETC_ADDR_RDATA: reg_rdata_o <= {22'h000000, rdata_q};
        `DTETC_ADDR_EGRESS: reg_rdata_o <= {9'h000, egr_q};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

  // lookup has no reset on data path; undefined until host writes entry
  always @(posedge clk_i) begin
    lookup_prob_o <= shadow[lookup_idx_i];
  end

  // one edit decision per egress port
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
      dtetc_tag_edit u_edit (
        .cfg_i(egr_q[gi*`DTETC_PORT_STRIDE +: 7]),
        .pkt_tagged_i(pkt_tagged_i[gi]),
        .pkt_vid_i(pkt_vid_i[gi*12 +: 12]),
        .untag_default_i(untag_default_i[gi]),
        .untag_incoming_i(untag_incoming_i[gi]),
        .insert_o(ins_w[gi]),
        .strip_o(strip_w[gi]),
        .vid_rewrite_o(vid_w[gi]),
        .pri_rewrite_o(pri_w[gi]),
        .use_egress_src_o(src_w[gi])
      );
    end
  endgenerate

  // register the decisions so outputs come from flops
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      insert_o <= {NPORT{1'b0}};
      strip_o <= {NPORT{1'b0}};
      vid_rewrite_o <= {NPORT{1'b0}};
      pri_rewrite_o <= {NPORT{1'b0}};
      use_egress_src_o <= {NPORT{1'b0}};
    end else begin
      insert_o <= ins_w;
      strip_o <= strip_w;
      vid_rewrite_o <= vid_w;
      pri_rewrite_o <= pri_w;
      use_egress_src_o <= src_w;
    end
  end
endmodule // dtetc_top

// >>> dtetc_asserts.sv
// checker for the discard table and egress tagging block
`timescale 1ns/1ps
module dtetc_asserts #(
  parameter NPORT = 3
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire [NPORT-1:0] pkt_tagged_i,
  input wire [12*NPORT-1:0] pkt_vid_i,
  input wire [NPORT-1:0] untag_default_i,
  input wire [NPORT-1:0] untag_incoming_i,
  input wire [NPORT-1:0] insert_o,
  input wire [NPORT-1:0] strip_o,
  input wire [NPORT-1:0] vid_rewrite_o,
  input wire [NPORT-1:0] pri_rewrite_o,
  input wire [NPORT-1:0] use_egress_src_o
);
  // port 0 config as the egress register holds it; a write lands at the
  // edge and the decisions built from it show one edge later
  reg [6:0] cfg_q;
  wire we = reg_wr_i && reg_addr_i == 16'h1C0C;
  wire [6:0] c = cfg_q;
  wire hy = c[1:0] == 2'h2;
  wire tg = pkt_tagged_i[0] && !untag_incoming_i[0];
  wire pt = pkt_vid_i[11:0] == 12'h000;
  wire e_ins = hy && !pkt_tagged_i[0] && c[5] && !untag_default_i[0];
  wire e_vid = hy && tg && (pt || c[4] && c[2]);
  wire e_pri = hy && tg && c[3] && (pt || c[2]);
  wire e_src = hy && c[6];
  wire rd_un = reg_rd_i && (reg_addr_i < 16'h1C09 || reg_addr_i > 16'h1C0C);
  // mirror of the port 0 fields of the egress register
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      cfg_q <= 7'h00;
    else if (we)
      cfg_q <= reg_wdata_i[6:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_ins_gate: assert property (
    $past(nrst_i) |-> insert_o[0] == $past(e_ins)) else $error("insert");
  a_vid_gate: assert property (
    $past(nrst_i) |-> vid_rewrite_o[0] == $past(e_vid)) else $error("vid");
  a_pri_gate: assert property (
    $past(nrst_i) |-> pri_rewrite_o[0] == $past(e_pri)) else $error("pri");
  a_src_gate: assert property (
    $past(nrst_i) |-> use_egress_src_o[0] == $past(e_src)) else $error("src");
  a_strip_wins: assert property (
    strip_o[0] |-> !vid_rewrite_o[0] && !pri_rewrite_o[0]) else $error("strip");
  a_untag_plain: assert property (
    !pkt_tagged_i[0] |=> !vid_rewrite_o[0] && !strip_o[0]) else $error("untag");
  a_rdata_hold: assert property (
    $past(nrst_i) && !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("rdata moved");
  a_unmapped_zero: assert property (
    rd_un |=> reg_rdata_o == 32'h0) else $error("unmapped");
  c_ins: cover property (e_ins ##1 insert_o[0]);
  c_vid: cover property (e_vid && pt);
  c_un: cover property (rd_un);
endmodule // dtetc_asserts
bind dtetc_top dtetc_asserts #(.NPORT(NPORT)) dtetc_asserts_i (.clk_i, .nrst_i,
  .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .pkt_tagged_i,
  .pkt_vid_i, .untag_default_i, .untag_incoming_i, .insert_o, .strip_o,
  .vid_rewrite_o, .pri_rewrite_o, .use_egress_src_o);

// >>> test_dtetc_top.sv
// self-checking bench for the discard table and egress tagging block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("FAIL %0t got %h", $time, a); end end
module test_dtetc_top;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [15:0] reg_addr_i = 16'h0000;
  reg [31:0] reg_wdata_i = 32'h0;
  reg [3:0] idx = 4'h0;
  reg [2:0] tg = 3'h0, ud = 3'h0, ui = 3'h0;
  reg [35:0] vid = 36'h0;
  wire [31:0] reg_rdata_o;
  wire [9:0] prob;
  wire [2:0] ins, stp, vrw, prw, src;
  int n_fail = 0, check_count = 0, i;
  dtetc_top dtetc_top_i (.clk_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .lookup_idx_i(idx), .lookup_prob_o(prob),
    .pkt_tagged_i(tg), .pkt_vid_i(vid), .untag_default_i(ud),
    .untag_incoming_i(ui), .insert_o(ins), .strip_o(stp),
    .vid_rewrite_o(vrw), .pri_rewrite_o(prw), .use_egress_src_o(src));
  initial forever #50 clk_i = ~clk_i;
  // one host access; held over the sampling edge, so a gap cycle follows
  task acc(input w, input [15:0] a, input [31:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask
  task t_regs;
    acc(0, 16'h1C0A, 32'h0);
    `CHK(reg_rdata_o, 32'h0)
    acc(1, 16'h1C0A, 32'hFFFFFFFF);
    acc(0, 16'h1C0A, 32'h0);
    `CHK(reg_rdata_o, 32'h3FF)
    acc(1, 16'h1C0B, 32'h155);
    acc(0, 16'h1C0B, 32'h0);
    `CHK(reg_rdata_o, 32'h0)
    acc(1, 16'h1C0C, 32'hFFFFFFFF);
    acc(0, 16'h1C0C, 32'h0);
    `CHK(reg_rdata_o, 32'h007F7F7F)
    acc(0, 16'h1C10, 32'h0);
    `CHK(reg_rdata_o, 32'h0)
    $display("register test done");
  endtask
  // fill every entry, then read back through both paths
  task t_table;
    for (i = 0; i < 16; i++) begin
      acc(1, 16'h1C0A, 32'h3FF - i * 61);
      acc(1, 16'h1C09, i);
    end
    for (i = 0; i < 16; i++) begin
      acc(1, 16'h1C09, 32'h10 | i);
      repeat (2) @(negedge clk_i);
      acc(0, 16'h1C0B, 32'h0);
      `CHK(reg_rdata_o, 32'h3FF - i * 61)
      idx = i[3:0];
      @(negedge clk_i);
      `CHK(prob, 10'(32'h3FF - i * 61))
    end
    acc(0, 16'h1C09, 32'h0);
    `CHK(reg_rdata_o, 32'h1F)
    $display("table test done");
  endtask
  // same config on all three ports; e is {ins, strip, vid, pri, src}
  task tc(input [6:0] c, input t, input [11:0] v, input u_d, u_i,
    input [4:0] e);
    tg = {3{t}};
    vid = {3{v}};
    ud = {3{u_d}};
    ui = {3{u_i}};
    acc(1, 16'h1C0C, {9'h000, c, 1'b0, c, 1'b0, c});
    @(negedge clk_i);
    `CHK({ins, stp, vrw, prw, src},
      {{3{e[4]}}, {3{e[3]}}, {3{e[2]}}, {3{e[1]}}, {3{e[0]}}})
  endtask
  task t_tag;
    for (i = 0; i < 4; i++)
      tc({5'h1F, i[1:0]}, 0, 12'h0, 0, 0, {i == 2, 3'h0, i == 2});
    tc(7'h7E, 0, 12'h000, 1, 0, 5'h01);
    tc(7'h0A, 1, 12'h000, 0, 0, 5'h06);
    tc(7'h1A, 1, 12'h005, 0, 0, 5'h00);
    tc(7'h1E, 1, 12'h005, 0, 0, 5'h06);
    tc(7'h1E, 1, 12'h000, 0, 1, 5'h08);
    $display("tag test done");
  endtask
  task finish_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    t_regs;
    t_table;
    t_tag;
    finish_test;
  end
  // the full run needs well under a thousand cycles
  initial begin
    #2000000;
    n_fail++;
    finish_test;
  end
endmodule // test_dtetc_top
